// ### rtl/pin_share_pkg.sv
// Constants and types shared by the memory pin sharing and LED logic
package pin_share_pkg;

  // ----------------------------------------------------------------
  // Clock and timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS       = 20;
  // 312.5 kHz output clock: 3200 ns period, toggled every half period
  localparam int COAX_HALF_PERIOD_NS = 1600;
  localparam int COAX_HALF_CYCLES    = COAX_HALF_PERIOD_NS / CLK_PERIOD_NS;
  localparam int COAX_CNT_W          = 7;
  localparam int LED_ON_MS           = 80;
  localparam int LED_OFF_MS          = 50;
  localparam int NS_PER_MS           = 1000000;
  localparam int LED_ON_CYCLES_DFLT  = LED_ON_MS * NS_PER_MS / CLK_PERIOD_NS;
  localparam int LED_OFF_CYCLES_DFLT = LED_OFF_MS * NS_PER_MS / CLK_PERIOD_NS;
  localparam int LED_CNT_W           = 22;

  // ----------------------------------------------------------------
  // Memory data line positions
  // ----------------------------------------------------------------
  localparam int MEM_DATA_W     = 8;
  localparam int EE_DIN_BIT     = 0;
  localparam int EE_DOUT_BIT    = 1;
  localparam int EE_CLK_BIT     = 2;
  localparam int LED_STRAP_BIT  = 2;
  localparam int COAX_STRAP_BIT = 5;
  localparam int WIDE_STRAP_BIT = 6;
  localparam int ROM_PAGE_W     = 8;

  // ----------------------------------------------------------------
  // Configuration register B fields
  // ----------------------------------------------------------------
  localparam int CFGB_W       = 2;
  localparam int CFGB_EN0_BIT = 0;
  localparam int CFGB_EN1_BIT = 1;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic                  STRAP_RST    = 1'h0;
  localparam logic [MEM_DATA_W-1:0] MEM_OE_N_RST = 8'hFF;
  localparam logic [MEM_DATA_W-1:0] MEM_OUT_RST  = 8'h00;
  localparam logic [ROM_PAGE_W-1:0] ROM_PAGE_RST = 8'h00;

  typedef enum logic [1:0] {
    LED_IDLE,
    LED_PULSE,
    LED_GAP
  } led_state_e;

endpackage

// ### rtl/memory_pin_sharing_and_led.sv
// Boot memory pin sharing, strap capture, coax enable and link LED driver
`timescale 1ns/1ps

// Behaviour
// - During EEPROM load or write, the lowest three memory data lines serve the EEPROM.
// - Line 0 carries data from the EEPROM; line 1 carries data to it.
// - Line 2 carries the EEPROM serial clock in EEPROM mode.
// - In reset, LED mode, coax clock and bus width straps are read from data lines.
// - Coax clock strap high makes the coax enable pin a steady 312.5 kHz clock.
// - Bus width strap high selects the legacy 16-bit host data mode.
// - On boot ROM access the page address pins carry the ROM page value.
// - Otherwise coax enable is high only when config B bit 1 low, bit 0 high.
// - The open-drain LED pin is pulled low while the twisted-pair link passes, except in the gap after a traffic pulse.
// - Traffic pulses the LED low for 80 ms, then releases it 50 ms.
// - The EEPROM select output is high while the EEPROM is selected.
// - The boot ROM select goes low only while the host reads ROM data.
module memory_pin_sharing_and_led
  import pin_share_pkg::*;
#(
  parameter int LED_ON_CYCLES  = LED_ON_CYCLES_DFLT,
  parameter int LED_OFF_CYCLES = LED_OFF_CYCLES_DFLT
) (
  input  wire logic                  clk,
  input  wire logic                  srst,
  input  wire logic [MEM_DATA_W-1:0] bootMemDataIn,
  output logic      [MEM_DATA_W-1:0] bootMemDataOut,
  output logic      [MEM_DATA_W-1:0] bootMemDataOe_n,
  output logic      [MEM_DATA_W-1:0] romData,
  input  wire logic                  eepromActive,
  input  wire logic                  eepromSelReq,
  input  wire logic                  eepromSerialOut,
  input  wire logic                  eepromSerialClock,
  output logic                       eepromSerialIn,
  output logic                       eepromSelect,
  input  wire logic                  romAccess,
  input  wire logic [ROM_PAGE_W-1:0] romPage,
  output logic      [ROM_PAGE_W-1:0] romPageAddr,
  output logic                       romSelect_n,
  output logic                       ledModeStrap,
  output logic                       coaxClockStrap,
  output logic                       wideBusMode,
  input  wire logic [CFGB_W-1:0]     configRegB,
  output logic                       coaxEnableOut,
  input  wire logic                  linkPass,
  input  wire logic                  trafficEvent,
  output logic                       linkTrafficLedOut,
  output logic                       linkTrafficLedOe_n
);

  localparam logic [COAX_CNT_W-1:0] COAX_LAST = COAX_CNT_W'(COAX_HALF_CYCLES - 1);
  localparam logic [LED_CNT_W-1:0]  LED_ON_LAST  = LED_CNT_W'(LED_ON_CYCLES - 1);
  localparam logic [LED_CNT_W-1:0]  LED_OFF_LAST = LED_CNT_W'(LED_OFF_CYCLES - 1);

  // Lines that the device drives while the EEPROM owns the bus
  function automatic logic [MEM_DATA_W-1:0] eeDriveMask(input logic active);
    logic [MEM_DATA_W-1:0] mask;
    mask = '0;
    mask[EE_DOUT_BIT] = active;
    mask[EE_CLK_BIT]  = active;
    return mask;
  endfunction

  function automatic logic coaxEnDecode(input logic [CFGB_W-1:0] cfg);
    return !cfg[CFGB_EN1_BIT] && cfg[CFGB_EN0_BIT];
  endfunction

  // ----------------------------------------------------------------
  // Pin synchroniser
  // ----------------------------------------------------------------
  // No reset here: straps must flow through while reset is held
  logic [MEM_DATA_W-1:0] memSync1_q;
  logic [MEM_DATA_W-1:0] memSync2_q;
  logic [MEM_DATA_W-1:0] memSync3_q;
  logic [MEM_DATA_W-1:0] memFilt_q;
  logic [MEM_DATA_W-1:0] memFilt_d;

  always_comb begin
    memFilt_d = (memSync3_q & ~(memSync2_q ^ memSync3_q))
              | (memFilt_q & (memSync2_q ^ memSync3_q));
  end

  always_ff @(posedge clk) begin
    memSync1_q <= bootMemDataIn;
    memSync2_q <= memSync1_q;
    memSync3_q <= memSync2_q;
    memFilt_q  <= memFilt_d;
  end

  // ----------------------------------------------------------------
  // Strap capture
  // ----------------------------------------------------------------
  // Sampled throughout reset, frozen at release so later ROM or EEPROM
  // traffic on the same lines cannot disturb the configuration
  always_ff @(posedge clk) begin
    if (srst) begin
      ledModeStrap   <= memFilt_q[LED_STRAP_BIT];
      coaxClockStrap <= memFilt_q[COAX_STRAP_BIT];
      wideBusMode    <= memFilt_q[WIDE_STRAP_BIT];
    end
  end

  // ----------------------------------------------------------------
  // EEPROM sharing
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (srst) begin
      bootMemDataOe_n <= MEM_OE_N_RST;
      bootMemDataOut  <= MEM_OUT_RST;
    end else begin
      bootMemDataOe_n <= ~eeDriveMask(eepromActive);
      bootMemDataOut  <= MEM_OUT_RST;
      bootMemDataOut[EE_DOUT_BIT] <= eepromActive && eepromSerialOut;
      bootMemDataOut[EE_CLK_BIT]  <= eepromActive && eepromSerialClock;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      eepromSerialIn <= STRAP_RST;
      eepromSelect   <= 1'h0;
    end else begin
      if (eepromActive) begin
        eepromSerialIn <= memFilt_q[EE_DIN_BIT];
      end
      eepromSelect <= eepromActive && eepromSelReq;
    end
  end

  // ----------------------------------------------------------------
  // Boot ROM
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (srst) begin
      romPageAddr <= ROM_PAGE_RST;
      romSelect_n <= 1'h1;
      romData     <= MEM_OUT_RST;
    end else begin
      if (romAccess) begin
        romPageAddr <= romPage;
      end
      romSelect_n <= !(romAccess && !eepromActive);
      romData     <= memFilt_q;
    end
  end

  // ----------------------------------------------------------------
  // Coax enable / clock output
  // ----------------------------------------------------------------
  // Free-running divider: the first half period after reset is one cycle longer
  logic [COAX_CNT_W-1:0] coaxCnt_q;
  logic                  coaxTick_q;

  always_ff @(posedge clk) begin
    if (srst) begin
      coaxCnt_q  <= '0;
      coaxTick_q <= 1'h0;
    end else if (coaxCnt_q == COAX_LAST) begin
      coaxCnt_q  <= '0;
      coaxTick_q <= 1'h1;
    end else begin
      coaxCnt_q  <= coaxCnt_q + COAX_CNT_W'(1);
      coaxTick_q <= 1'h0;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      coaxEnableOut <= 1'h0;
    end else if (coaxClockStrap) begin
      if (coaxTick_q) begin
        coaxEnableOut <= !coaxEnableOut;
      end
    end else begin
      coaxEnableOut <= coaxEnDecode(configRegB);
    end
  end

  // ----------------------------------------------------------------
  // Link and traffic LED
  // ----------------------------------------------------------------
  // Traffic blinks override the steady link-pass glow so activity stays
  // visible; new traffic during a blink is absorbed, not queued
  led_state_e           ledState_q;
  logic [LED_CNT_W-1:0] ledCnt_q;

  always_ff @(posedge clk) begin
    if (srst) begin
      ledState_q <= LED_IDLE;
      ledCnt_q   <= '0;
    end else begin
      case (ledState_q)
        LED_IDLE: begin
          ledCnt_q <= '0;
          if (trafficEvent) begin
            ledState_q <= LED_PULSE;
          end
        end
        LED_PULSE: begin
          if (ledCnt_q == LED_ON_LAST) begin
            ledState_q <= LED_GAP;
            ledCnt_q   <= '0;
          end else begin
            ledCnt_q <= ledCnt_q + LED_CNT_W'(1);
          end
        end
        LED_GAP: begin
          if (ledCnt_q == LED_OFF_LAST) begin
            ledState_q <= LED_IDLE;
            ledCnt_q   <= '0;
          end else begin
            ledCnt_q <= ledCnt_q + LED_CNT_W'(1);
          end
        end
        default: begin
          ledState_q <= LED_IDLE;
          ledCnt_q   <= '0;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      linkTrafficLedOut  <= 1'h0;
      linkTrafficLedOe_n <= 1'h1;
    end else begin
      linkTrafficLedOut  <= 1'h0;
      linkTrafficLedOe_n <= !((ledState_q == LED_IDLE && linkPass)
                              || ledState_q == LED_PULSE);
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (srst);
  // Outputs are registered, so most checks look one edge after their inputs

  a_ee_pin_dir: assert property (eepromActive |=> bootMemDataOe_n == ~eeDriveMask(1'b1))
    else $error("EEPROM lines not driven as expected");
  a_rom_lines_free: assert property (!eepromActive |=> bootMemDataOe_n == MEM_OE_N_RST)
    else $error("Memory data driven outside EEPROM mode");
  a_ee_data_in: assert property (eepromActive |=>
      eepromSerialIn == $past(memFilt_q[EE_DIN_BIT]))
    else $error("EEPROM input data not taken from line 0");
  a_ee_in_hold: assert property (!eepromActive |=> $stable(eepromSerialIn))
    else $error("EEPROM input data changed outside EEPROM mode");
  a_spare_lines_low: assert property (##1
      (bootMemDataOut & ~eeDriveMask(1'b1)) == MEM_OUT_RST)
    else $error("Memory data line outside the EEPROM set driven high");
  a_ee_data_out: assert property (eepromActive |=>
      bootMemDataOut[EE_DOUT_BIT] == $past(eepromSerialOut))
    else $error("EEPROM output data not on line 1");
  a_ee_clock: assert property (eepromActive |=>
      bootMemDataOut[EE_CLK_BIT] == $past(eepromSerialClock))
    else $error("EEPROM clock not on line 2");
  a_strap_hold: assert property ($past(!srst) |->
      $stable({ledModeStrap, coaxClockStrap, wideBusMode}))
    else $error("Strap changed outside reset");
  a_coax_toggle: assert property (coaxClockStrap && coaxTick_q |=> $changed(coaxEnableOut))
    else $error("Coax clock missed a half period edge");
  a_coax_steady: assert property (coaxClockStrap && !coaxTick_q |=> $stable(coaxEnableOut))
    else $error("Coax clock changed between ticks");
  a_coax_tick_gap: assert property (coaxTick_q |=> (!coaxTick_q) [*8])
    else $error("Coax divider ticks too close");
  a_coax_cfg_follow: assert property (!coaxClockStrap |=>
      coaxEnableOut == coaxEnDecode($past(configRegB)))
    else $error("Coax enable does not follow config B");
  a_page_addr: assert property (romAccess |=> romPageAddr == $past(romPage))
    else $error("ROM page address not presented");
  a_page_hold: assert property (!romAccess |=> $stable(romPageAddr))
    else $error("ROM page address changed between accesses");
  a_rom_select: assert property (##1 romSelect_n == !$past(romAccess && !eepromActive))
    else $error("ROM select wrong");
  a_ee_select: assert property (##1 eepromSelect == $past(eepromActive && eepromSelReq))
    else $error("EEPROM select wrong");
  a_ee_sel_idle: assert property (!eepromActive |=> !eepromSelect)
    else $error("EEPROM selected outside EEPROM mode");
  a_led_link: assert property (ledState_q == LED_IDLE && linkPass |=> !linkTrafficLedOe_n)
    else $error("LED not low on link pass");
  a_led_idle_dark: assert property (ledState_q == LED_IDLE && !linkPass |=> linkTrafficLedOe_n)
    else $error("LED lit without link or traffic");
  a_led_pulse_low: assert property (ledState_q == LED_PULSE |=> !linkTrafficLedOe_n)
    else $error("LED not low during traffic pulse");
  a_led_gap_len: assert property (ledState_q == LED_IDLE && $past(ledState_q) == LED_GAP
      |-> $past(ledCnt_q) == LED_OFF_LAST)
    else $error("LED gap length wrong");
  a_led_pulse_len: assert property (ledState_q == LED_GAP && $past(ledState_q) == LED_PULSE
      |-> $past(ledCnt_q) == LED_ON_LAST)
    else $error("LED pulse length wrong");
  a_led_gap_release: assert property (ledState_q == LED_GAP |=> linkTrafficLedOe_n)
    else $error("LED not released during gap");

  c_ee_mode: cover property (eepromActive ##1 eepromActive && eepromSelect);
  c_coax_edge: cover property (coaxClockStrap && $changed(coaxEnableOut));
  c_led_blink: cover property (ledState_q == LED_PULSE ##1 ledState_q == LED_GAP);
  c_rom_read: cover property (romAccess ##1 !romSelect_n);
  c_link_glow: cover property (ledState_q == LED_IDLE && linkPass ##1 !linkTrafficLedOe_n);

endmodule

// ### verif/rom_eeprom_model.sv
// Far-side model: boot ROM, serial EEPROM and strap resistors on the memory lines
`timescale 1ns/1ps
module rom_eeprom_model
  import pin_share_pkg::*;
(
  input  wire logic [MEM_DATA_W-1:0] pinOut,
  input  wire logic [MEM_DATA_W-1:0] pinOe_n,
  input  wire logic                  romSel_n,
  input  wire logic                  eeSel,
  input  wire logic [MEM_DATA_W-1:0] pullHigh,
  input  wire logic [MEM_DATA_W-1:0] romByte,
  input  wire logic                  eeBit,
  output logic      [MEM_DATA_W-1:0] pinLevel
);
  // ----------------------------------------------------------------
  // Line resolution
  // ----------------------------------------------------------------
  // Released lines carry the ROM byte, or on line 0 the EEPROM bit, when selected; else the weak pull-low unless a strap resistor pulls high
  always_comb begin
    for (int i = 0; i < MEM_DATA_W; i++) begin
      if (!pinOe_n[i]) pinLevel[i] = pinOut[i];
      else if (!romSel_n) pinLevel[i] = romByte[i];
      else if (eeSel && i == EE_DIN_BIT) pinLevel[i] = eeBit;
      else pinLevel[i] = pullHigh[i];
    end
  end
endmodule

// ### verif/memory_pin_sharing_and_led_test.sv
// Self-checking bench for the memory pin sharing and LED logic
`timescale 1ns/1ps
`define CHECK(nm, e, g) begin check_count++; if ((g) !== (e)) begin miscompares++; \
  $display("ERROR %s exp %0h got %0h", nm, e, g); end end
module memory_pin_sharing_and_led_test
  import pin_share_pkg::*;
;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  localparam int ON_C  = 20;
  localparam int OFF_C = 12;
  logic       clk, srst, eepromActive, eepromSelReq, eepromSerialOut, eepromSerialClock;
  logic       romAccess, linkPass, trafficEvent, eeBit, eepromSerialIn, eepromSelect;
  logic       romSelect_n, ledModeStrap, coaxClockStrap, wideBusMode, coaxEnableOut;
  logic       linkTrafficLedOut, linkTrafficLedOe_n;
  logic [7:0] romPage, pullHigh, romByte, bootMemDataIn, bootMemDataOut, bootMemDataOe_n;
  logic [7:0] romData, romPageAddr, savedPull, lastPage;
  logic [1:0] configRegB;
  int         miscompares = 0;
  int         check_count = 0;
  int         n;

  memory_pin_sharing_and_led #(.LED_ON_CYCLES(ON_C), .LED_OFF_CYCLES(OFF_C)) i_dut (
    .clk, .srst, .bootMemDataIn, .bootMemDataOut, .bootMemDataOe_n, .romData, .eepromActive,
    .eepromSelReq, .eepromSerialOut, .eepromSerialClock, .eepromSerialIn, .eepromSelect,
    .romAccess, .romPage, .romPageAddr, .romSelect_n, .ledModeStrap, .coaxClockStrap,
    .wideBusMode, .configRegB, .coaxEnableOut, .linkPass, .trafficEvent, .linkTrafficLedOut,
    .linkTrafficLedOe_n);

  rom_eeprom_model i_far (.pinOut(bootMemDataOut), .pinOe_n(bootMemDataOe_n),
    .romSel_n(romSelect_n), .eeSel(eepromSelect), .pullHigh(pullHigh), .romByte(romByte),
    .eeBit(eeBit), .pinLevel(bootMemDataIn));

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  initial begin
    clk = 0;
    forever #10 clk = ~clk;
  end

  task automatic step(int k);
    repeat (k) @(posedge clk);
    #1;
  endtask

  // Straps need the sync chain filled, so strap resets run longer than the first
  task automatic do_reset(int k);
    srst = 1;
    step(k);
    srst = 0;
  endtask

  function automatic logic coax_exp(logic [1:0] b);
    return !b[CFGB_EN1_BIT] && b[CFGB_EN0_BIT];
  endfunction

  task automatic run_len(input logic sig, output int len);
    len = 0;
    while (coaxEnableOut === sig && len < 400) begin
      step(1);
      len++;
    end
  endtask

  task automatic close_out();
    $display("checks %0d miscompares %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  initial begin
    #(20 * 6000);
    miscompares++;
    close_out();
  end

  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    {eepromActive, eepromSelReq, eepromSerialOut, eepromSerialClock, romAccess} = '0;
    {linkPass, trafficEvent, eeBit, configRegB, romPage, romByte, pullHigh} = '0;
    srst = 1;
    n = $urandom(32'hAB16);
    do_reset(2);
    step(1);
    for (int it = 0; it < 5; it++) begin
      savedPull = (it == 0) ? 8'h00 : (it == 1) ? 8'hFF : 8'($urandom);
      pullHigh = savedPull;
      do_reset(6);
      pullHigh = ~savedPull;
      step(8);
      `CHECK("ledStrap", savedPull[LED_STRAP_BIT], ledModeStrap)
      `CHECK("coaxStrap", savedPull[COAX_STRAP_BIT], coaxClockStrap)
      `CHECK("wideBus", savedPull[WIDE_STRAP_BIT], wideBusMode)
    end
    pullHigh = 8'h20;
    do_reset(6);
    pullHigh = 8'h00;
    configRegB = 2'h1;
    run_len(coaxEnableOut, n);
    for (int h = 0; h < 2; h++) begin
      configRegB = 2'($urandom);
      run_len(coaxEnableOut, n);
      `CHECK("coaxHalf", COAX_HALF_CYCLES, n)
    end
    do_reset(6);
    for (int b = 0; b < 6; b++) begin
      configRegB = (b < 4) ? 2'(b) : 2'($urandom);
      step(2);
      `CHECK("coaxEn", coax_exp(configRegB), coaxEnableOut)
    end
    repeat (8) begin
      {eepromActive, eepromSelReq} = 2'h3;
      {eepromSerialOut, eepromSerialClock, eeBit} = 3'($urandom);
      step(6);
      `CHECK("eeOe", 8'hF9, bootMemDataOe_n)
      `CHECK("eeOut", eepromSerialOut, bootMemDataOut[EE_DOUT_BIT])
      `CHECK("eeClk", eepromSerialClock, bootMemDataOut[EE_CLK_BIT])
      `CHECK("eeIn", eeBit, eepromSerialIn)
      `CHECK("eeSel", 1'b1, eepromSelect)
    end
    {eepromActive, eepromSelReq} = 2'h0;
    step(2);
    `CHECK("eeOff", 8'hFF, bootMemDataOe_n)
    `CHECK("eeSelOff", 1'b0, eepromSelect)
    repeat (8) begin
      romAccess = 1;
      romPage = 8'($urandom);
      lastPage = romPage;
      romByte = 8'($urandom);
      step(7);
      `CHECK("page", lastPage, romPageAddr)
      `CHECK("romSel", 1'b0, romSelect_n)
      `CHECK("romData", romByte, romData)
      romAccess = 0;
      romPage = ~lastPage;
      step(2);
      `CHECK("romIdle", 1'b1, romSelect_n)
      `CHECK("pageHold", lastPage, romPageAddr)
    end
    {romAccess, eepromActive} = 2'h3;
    step(2);
    `CHECK("romInEe", 1'b1, romSelect_n)
    {romAccess, eepromActive} = 2'h0;
    linkPass = 1;
    step(2);
    `CHECK("linkLed", 1'b0, linkTrafficLedOe_n)
    `CHECK("ledLevel", 1'b0, linkTrafficLedOut)
    linkPass = 0;
    step(2);
    `CHECK("ledOff", 1'b1, linkTrafficLedOe_n)
    trafficEvent = 1;
    step(1);
    trafficEvent = 0;
    step(1);
    linkPass = 1;
    // Count low then released spans; link pass must not mask the gap
    for (int s = 0; s < 2; s++) begin
      n = 0;
      while (linkTrafficLedOe_n === 1'(s) && n < 100) begin
        step(1);
        n++;
      end
      `CHECK("ledSpan", s ? OFF_C : ON_C, n)
    end
    close_out();
  end
endmodule
